/* bench/mss_far_model.sv */
// Purpose: Control store and instruction memory facing the sequencer.
// Assumes: Both answer combinationally well within a phase.
// Notes:   Slot 8 of memory holds the user opcode; others decode to 0x080 plus slot.
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_far_model
  import mss_pkg::*;
(
  // Control store side.
  input  wire logic [9:0]  cs_addr_in,
  output logic      [55:0] cs_word_out,
  // Memory side.
  input  wire logic        mem_rd_in,
  input  wire logic [15:0] mem_addr_in,
  output logic      [15:0] mem_data_out
);
  logic [47:0] w;
  logic [3:0]  slot;

  always_comb begin
    w = '0;
    w[`MSS_F_LIT_HI:`MSS_F_LIT_LO] = cs_addr_in[7:0] ^ 8'h5A;
    // Operand and result fields follow the address so each word names its own.
    w[`MSS_F_LIT_EN] = cs_addr_in[1];
    w[`MSS_F_ASRC_HI:`MSS_F_ASRC_LO] = cs_addr_in[4:0];
    w[`MSS_F_BSRC_HI:`MSS_F_BSRC_LO] = ~cs_addr_in[4:0];
    w[`MSS_F_DST_HI:`MSS_F_DST_LO] = cs_addr_in[5:1];
    if (cs_addr_in == 10'h000) begin
      w[`MSS_F_FETCH] = 1'h1;
      w[`MSS_F_NEXT_LO] = 1'h1;
    end else if (cs_addr_in == 10'h001) begin
      w[`MSS_F_SEQ_HI:`MSS_F_SEQ_LO] = MSS_SEQ_DECODE;
    end else if (cs_addr_in[9:4] == 6'h08) begin
      w[`MSS_F_COND_HI:`MSS_F_COND_LO] = cs_addr_in[2:0];
      w[`MSS_F_NEXT_HI:`MSS_F_NEXT_LO] = 10'h020;
      w[`MSS_F_STEER] = 1'h1;
      w[`MSS_F_PAIR_HI:`MSS_F_PAIR_LO] = 2'h2;
    end else if (cs_addr_in == 10'h3C0) begin
      w[`MSS_F_SEQ_HI:`MSS_F_SEQ_LO] = MSS_SEQ_RSVD;
      w[`MSS_F_NEXT_HI:`MSS_F_NEXT_LO] = 10'h021;
      w[`MSS_F_STEER] = 1'h1;
      w[`MSS_F_PAIR_HI:`MSS_F_PAIR_LO] = 2'h3;
      w[`MSS_F_CLKD] = 1'h1;
      w[`MSS_F_WHEN] = 1'h1;
    end else if (cs_addr_in != 10'h010) begin
      w[`MSS_F_SEQ_HI:`MSS_F_SEQ_LO] = MSS_SEQ_SERVICE;
      w[`MSS_F_PAIR_LO] = 1'h1;
      w[`MSS_F_CLKD] = 1'h1;
    end
  end
  assign cs_word_out = {~cs_addr_in[7:0], w};
  assign slot = mem_addr_in[4:1];
  // A released bus shows a moving pattern, never the last word.
  assign mem_data_out = !mem_rd_in ? ~mem_addr_in :
                        (slot == 4'h8) ? 16'h7DD5 : {3'h0, slot, 9'h000};
endmodule
`default_nettype wire

/* bench/mss_seq_chk_assertions.sv */
// Purpose: Port-level checks of microcycle timing and successor selection.
// Assumes: One clock; synchronous active-low reset.
// Notes:   Bound into every sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module mss_seq_chk #(
  parameter int UCYCLE_CLKS = 34
) (
  // Clock and reset.
  input wire logic        sys_clk_in,
  input wire logic        reset_n_in,
  // Sequencer outputs.
  input wire logic [9:0]  cs_addr_out,
  input wire logic [9:0]  uaddr_out,
  input wire logic        mem_rd_out,
  input wire logic        phase_one_pulse_out,
  input wire logic        phase_two_pulse_out,
  input wire logic        phase_three_pulse_out,
  input wire logic        micro_phase_three_pulse_out,
  input wire logic [3:0]  alu_fn_out,
  input wire logic [7:0]  literal_out,
  input wire logic        d_load_out,
  input wire logic [1:0]  sp_write_out,
  input wire logic [1:0]  reg_clk_out,
  input wire logic [15:0] pc_out,
  input wire logic [15:0] instruction_holding_register_out
);
  logic       p1;
  logic       p2;
  logic       p3;
  logic       up3;
  logic       up3_q_r;
  logic [6:0] gap_r;
  assign p1 = phase_one_pulse_out;
  assign p2 = phase_two_pulse_out;
  assign p3 = phase_three_pulse_out;
  assign up3 = micro_phase_three_pulse_out;

  // Clocks between trailing edges; zero until the first edge is seen after reset.
  always_ff @(posedge sys_clk_in) begin
    up3_q_r <= up3;
    if (!reset_n_in) begin
      gap_r <= 7'h00;
    end else if (up3_q_r && !up3) begin
      gap_r <= 7'h01;
    end else if (gap_r != 7'h00) begin
      gap_r <= gap_r + 7'h01;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_p1_width: assert property ($rose(p1) |-> p1 [*4] ##1 !p1)
    else $error("phase one width wrong");
  a_phase_order: assert property (
    $rose(p1) |-> ##8 $rose(p2) ##8 $rose(p3) ##8 $rose(up3))
    else $error("phase spacing wrong");
  a_up3_width: assert property ($rose(up3) |-> up3 [*6] ##1 !up3)
    else $error("slow pulse width wrong");
  a_cycle_len: assert property (
    (up3_q_r && !up3 && gap_r != 7'h00) |-> gap_r == 7'(UCYCLE_CLKS))
    else $error("microcycle length wrong");
  a_word_hold: assert property (
    $changed({alu_fn_out, uaddr_out, mem_rd_out}) |-> $fell(up3))
    else $error("microword changed mid cycle");
  a_addr_launch: assert property (
    $changed(cs_addr_out) |-> p3 && $past(p3) && !$past(p3, 2))
    else $error("store address moved off phase three");
  a_addr_take: assert property ($fell(up3) |-> uaddr_out == $past(cs_addr_out))
    else $error("taken address differs");
  a_lit_overlap: assert property (alu_fn_out == literal_out[7:4])
    else $error("literal and function bits differ");
  a_steer_excl: assert property (
    (|sp_write_out || |reg_clk_out) |-> p3 && !(|sp_write_out && |reg_clk_out))
    else $error("steered pair wrong");
  a_dload_phase: assert property (d_load_out |-> p2 || p3)
    else $error("register load off phase");
  a_pc_step: assert property (
    $changed(pc_out) |-> pc_out == $past(pc_out) + 16'h0002 && p3 && $past(p3) && !$past(p3, 2))
    else $error("counter step wrong");
  a_ir_load: assert property (
    $changed(instruction_holding_register_out) |-> mem_rd_out && p3 && $past(p3) && !$past(p3, 2))
    else $error("instruction load without fetch");
endmodule
bind mss_sequencer mss_seq_chk #(.UCYCLE_CLKS(UCYCLE_CLKS)) u_chk (.*);
`default_nettype wire

/* bench/testbench.sv */
// Purpose: Self-checking bench for the microword sequencer.
// Assumes: The far-side model holds a fixed microprogram and instruction list.
// Notes:   Each row walks one macro-instruction; resets are hand-written.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mss_pkg::*;
  typedef struct packed {
    logic       svc;
    logic       cy;
    logic       zr;
    logic [9:0] d;
    logic [9:0] b;
    logic [9:0] e;
  } mss_row_s;
  localparam mss_row_s ROWS [14] = '{
    '{1'h0, 1'h0, 1'h0, 10'h080, 10'h020, 10'h000},
    '{1'h0, 1'h1, 1'h0, 10'h081, 10'h021, 10'h000},
    '{1'h0, 1'h0, 1'h1, 10'h082, 10'h021, 10'h000},
    '{1'h1, 1'h0, 1'h0, 10'h083, 10'h021, 10'h010},
    '{1'h0, 1'h0, 1'h0, 10'h084, 10'h021, 10'h000},
    '{1'h0, 1'h0, 1'h1, 10'h085, 10'h020, 10'h000},
    '{1'h1, 1'h1, 1'h1, 10'h086, 10'h020, 10'h010},
    '{1'h0, 1'h1, 1'h1, 10'h087, 10'h020, 10'h000},
    '{1'h0, 1'h0, 1'h0, 10'h3C0, 10'h021, 10'h000},
    '{1'h0, 1'h0, 1'h1, 10'h089, 10'h020, 10'h000},
    '{1'h1, 1'h1, 1'h0, 10'h08A, 10'h020, 10'h010},
    '{1'h0, 1'h1, 1'h1, 10'h08B, 10'h020, 10'h000},
    '{1'h1, 1'h1, 1'h0, 10'h08C, 10'h020, 10'h010},
    '{1'h0, 1'h1, 1'h0, 10'h08D, 10'h021, 10'h000}
  };
  logic        sys_clk_in, reset_n_in, service_req_in, dp_carry_in, dp_zero_in;
  logic        mem_rd_out, d_load_out, phase_one_pulse_out, phase_two_pulse_out;
  logic        phase_three_pulse_out, micro_phase_three_pulse_out;
  logic [9:0]  cs_addr_out, uaddr_out;
  logic [55:0] cs_word_in;
  logic [15:0] mem_addr_out, mem_data_in, pc_out, instruction_holding_register_out;
  logic [3:0]  alu_fn_out;
  logic [7:0]  literal_out;
  logic [1:0]  sp_write_out, reg_clk_out;
  logic        literal_en_out;
  logic [4:0]  a_sel_out, b_sel_out, dst_sel_out;
  int          n_fail, comparisons;

  mss_sequencer uut (.*);
  mss_far_model far (.cs_addr_in(cs_addr_out), .cs_word_out(cs_word_in), .mem_rd_in(mem_rd_out),
                     .mem_addr_in(mem_addr_out), .mem_data_out(mem_data_in));

  initial begin
    sys_clk_in = 1'h0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic tick;
    @(posedge sys_clk_in);
    #1;
  endtask

  // Returns just after the next trailing edge of the slow pulse; n is clocks waited.
  task automatic step(output int n);
    logic prev;
    for (n = 1; n <= 80; n++) begin
      prev = micro_phase_three_pulse_out;
      tick();
      if (prev && !micro_phase_three_pulse_out) return;
    end
    n_fail++;
    finish_test();
  endtask

  task automatic ph_chk(input logic d2, input logic d3, input logic [1:0] sp, input logic [1:0] rc);
    int k;
    for (k = 0; k < 40 && !phase_two_pulse_out; k++) tick();
    chk(phase_two_pulse_out, 1'h1);
    chk(d_load_out, d2);
    for (k = 0; k < 40 && !phase_three_pulse_out; k++) tick();
    chk(d_load_out, d3);
    chk(sp_write_out, sp);
    chk(reg_clk_out, rc);
    if (!phase_three_pulse_out) begin
      n_fail++;
      finish_test();
    end
  endtask

  task automatic do_reset;
    int k;
    reset_n_in = 1'h0;
    for (k = 0; k < 6; k++) tick();
    chk({phase_one_pulse_out, phase_two_pulse_out, phase_three_pulse_out,
         micro_phase_three_pulse_out}, 4'h0);
    chk(uaddr_out, 10'h000);
    chk(cs_addr_out, 10'h000);
    chk(pc_out, 16'h0000);
    chk(instruction_holding_register_out, 16'h0000);
    reset_n_in = 1'h1;
    step(k);
    chk(mem_rd_out, 1'h1);
    $display("reset test done");
  endtask

  initial begin
    int i, g;
    service_req_in = 1'h0;
    dp_carry_in = 1'h0;
    dp_zero_in = 1'h0;
    n_fail = 0;
    comparisons = 0;
    do_reset();
    for (i = 0; i < 14; i++) begin
      if (uaddr_out !== 10'h000) step(g);
      chk(uaddr_out, 10'h000);
      {service_req_in, dp_carry_in, dp_zero_in} = {ROWS[i].svc, ROWS[i].cy, ROWS[i].zr};
      step(g);
      chk(g, 16'h0022);
      chk(uaddr_out, 10'h001);
      chk(instruction_holding_register_out, (i == 8) ? 16'h7DD5 : {3'h0, 4'(i), 9'h000});
      chk(pc_out, 16'(2 * i + 2));
      step(g);
      chk(uaddr_out, ROWS[i].d);
      chk(literal_out, ROWS[i].d[7:0] ^ 8'h5A);
      chk({literal_en_out, a_sel_out, b_sel_out, dst_sel_out},
          {ROWS[i].d[1], ROWS[i].d[4:0], ~ROWS[i].d[4:0], ROWS[i].d[5:1]});
      ph_chk(1'h0, i == 8, 2'h0, (i == 8) ? 2'h3 : 2'h2);
      step(g);
      chk(uaddr_out, ROWS[i].b);
      ph_chk(1'h1, 1'h0, 2'h1, 2'h0);
      step(g);
      chk(uaddr_out, ROWS[i].e);
      $display("row %0d done", i);
    end
    step(g);
    for (i = 0; i < 10; i++) tick();
    do_reset();
    step(g);
    chk(pc_out, 16'h0002);
    step(g);
    chk(uaddr_out, 10'h080);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
`default_nettype wire

/* inc/mss_defines.svh */
// Purpose: Numeric constants of the microword sequencer and its microcycle timing.
// Assumes: A 200 MHz system clock.
// Notes:   Definitions only; included by the package, the far-side model, the phase generator and the sequencer.
`ifndef MSS_DEFINES_SVH
`define MSS_DEFINES_SVH

// Clock and microcycle timing.
`define MSS_CLK_PERIOD_PS   5000
`define MSS_UCYCLE_NS       170
`define MSS_UCYCLE_CLKS     ((`MSS_UCYCLE_NS * 1000) / `MSS_CLK_PERIOD_PS)

// Phase pulse windows, in clock counts within one microcycle.
`define MSS_P1_START        4
`define MSS_P1_END          7
`define MSS_P2_START        12
`define MSS_P2_END          15
`define MSS_P3_START        20
`define MSS_P3_END          23
`define MSS_UP3_START       28
`define MSS_CNT_W           6

// Control store geometry.
`define MSS_UWORD_W         48
`define MSS_UWORD_EXT_W     56
`define MSS_UADDR_W         10
`define MSS_CS_DEPTH        1024

// Microword field positions.
`define MSS_F_ALU_HI        47
`define MSS_F_ALU_LO        44
`define MSS_F_LIT_HI        47
`define MSS_F_LIT_LO        40
`define MSS_F_LIT_EN        39
`define MSS_F_ASRC_HI       38
`define MSS_F_ASRC_LO       34
`define MSS_F_FETCH         33
`define MSS_F_WHEN          29
`define MSS_F_CLKD          28
`define MSS_F_BSRC_HI       27
`define MSS_F_BSRC_LO       23
`define MSS_F_DST_HI        22
`define MSS_F_DST_LO        18
`define MSS_F_STEER         17
`define MSS_F_PAIR_HI       16
`define MSS_F_PAIR_LO       15
`define MSS_F_COND_HI       14
`define MSS_F_COND_LO       12
`define MSS_F_SEQ_HI        11
`define MSS_F_SEQ_LO        10
`define MSS_F_NEXT_HI       9
`define MSS_F_NEXT_LO       0

// Fixed microcode entry points.
`define MSS_RESET_UADDR     10'h000
`define MSS_SERVICE_UADDR   10'h010
`define MSS_USER_DISPATCH   10'h3C0
`define MSS_DECODE_BASE     3'h1

// Macro-level decode and program counter step.
`define MSS_USER_OPC_HI     15
`define MSS_USER_OPC_LO     6
`define MSS_USER_OPC        10'h1F7
`define MSS_OPC_MAP_HI      15
`define MSS_OPC_MAP_LO      9
`define MSS_PC_STEP         16'h0002
`define MSS_PC_RESET        16'h0000

`endif

/* inc/mss_pkg.sv */
// Purpose: Types shared by the microword sequencer modules.
// Assumes: mss_defines.svh supplies the widths; the enum encodings are written here.
// Notes:   Holds types only.
`default_nettype none
`include "mss_defines.svh"
package mss_pkg;
  typedef logic [`MSS_UADDR_W-1:0] mss_uaddr_t;
  typedef logic [`MSS_UWORD_W-1:0] mss_uword_t;

  // Successor selection kinds.
  typedef enum logic [1:0] {
    MSS_SEQ_NEXT     = 2'b00,
    MSS_SEQ_DECODE   = 2'b01,
    MSS_SEQ_SERVICE  = 2'b10,
    MSS_SEQ_RSVD     = 2'b11
  } mss_seq_op_e;

  // Branch conditions; a true test sets bit 0 of the successor address.
  typedef enum logic [2:0] {
    MSS_COND_NONE    = 3'b000,
    MSS_COND_CARRY   = 3'b001,
    MSS_COND_ZERO    = 3'b010,
    MSS_COND_SERVICE = 3'b011,
    MSS_COND_NCARRY  = 3'b100,
    MSS_COND_NZERO   = 3'b101,
    MSS_COND_R6      = 3'b110,
    MSS_COND_R7      = 3'b111
  } mss_cond_e;
endpackage
`default_nettype wire

/* inc/mss_timing_if.sv */
// Purpose: Carries the microcycle phase pulses from the phase generator.
// Assumes: Single clock domain.
// Notes:   Every signal is a one-clock-wide or multi-clock level from flops.
`timescale 1ns/1ps
`default_nettype none
interface mss_timing_if;
  logic p1;
  logic p2;
  logic p3;
  logic up3;
  logic p3_begin;
  logic changeover;

  modport gen (output p1, p2, p3, up3, p3_begin, changeover);
  modport use_side (input p1, p2, p3, up3, p3_begin, changeover);
endinterface
`default_nettype wire

/* rtl/mss_phase_gen.sv */
// Purpose: Microcycle counter and the four phase pulses.
// Assumes: reset_n_in is synchronous and active low.
// Notes:   The last count of the cycle is the trailing edge of the micro-phase-three pulse.
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_phase_gen
  import mss_pkg::*;
#(
  parameter int UCYCLE_CLKS = `MSS_UCYCLE_CLKS
) (
  // Clock and reset.
  input  wire logic sys_clk_in,
  input  wire logic reset_n_in,
  // Phase pulses.
  mss_timing_if.gen tmg
);
  localparam logic [`MSS_CNT_W-1:0] LAST_CNT = `MSS_CNT_W'(UCYCLE_CLKS - 1);

  initial begin
    if (UCYCLE_CLKS <= `MSS_UP3_START + 1 || UCYCLE_CLKS > (1 << `MSS_CNT_W)) begin
      $error("mss_phase_gen: UCYCLE_CLKS out of range");
    end
  end

  logic [`MSS_CNT_W-1:0] cnt_r;
  logic [`MSS_CNT_W-1:0] cnt_nxt;
  wire                   wrap = (cnt_nxt == '0);

  assign cnt_nxt = (cnt_r == LAST_CNT) ? '0 : cnt_r + `MSS_CNT_W'(1);

  // [RULE9] four pulses per cycle
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      cnt_r          <= '0;
      tmg.p1         <= 1'b0;
      tmg.p2         <= 1'b0;
      tmg.p3         <= 1'b0;
      tmg.up3        <= 1'b0;
      tmg.p3_begin   <= 1'b0;
      tmg.changeover <= 1'b0;
    end else begin
      cnt_r          <= cnt_nxt;
      tmg.p1         <= (cnt_nxt >= `MSS_P1_START) && (cnt_nxt <= `MSS_P1_END);
      tmg.p2         <= (cnt_nxt >= `MSS_P2_START) && (cnt_nxt <= `MSS_P2_END);
      tmg.p3         <= (cnt_nxt >= `MSS_P3_START) && (cnt_nxt <= `MSS_P3_END);
      tmg.up3        <= (cnt_nxt >= `MSS_UP3_START);
      tmg.p3_begin   <= (cnt_nxt == `MSS_P3_START);
      // [RULE10] cycle ends at trailing edge
      tmg.changeover <= (cnt_nxt == LAST_CNT) && !wrap;
    end
  end
endmodule
`default_nettype wire

/* rtl/mss_sequencer.sv */
// Purpose: Microprogram sequencer and macro-level fetch, decode and service loop.
// Assumes: Control store and memory answer combinationally within a phase.
// Notes:   No microprogram counter; each successor comes from the microword, the instruction register or the fixed service address.
// Summary of operation
// [RULE1] Microword is 48 bits, one microinstruction.
// [RULE2] Only the common 48 bits are used.
// [RULE3] Next address from field, no counter.
// [RULE4] Branch test modifies next fetched address.
// [RULE5] Word names two sources, result, successor.
// [RULE6] Steer bit picks scratchpad or register clocks.
// [RULE7] Literal shares bits with ALU function.
// [RULE8] New microword governs whole cycle.
// [RULE9] 170 ns cycle with four pulses.
// [RULE10] Cycle bounded by micro-phase-three trailing edges.
// [RULE11] Phases sequence transfers; ALU result at P2.
// [RULE12] Fetch loads instruction, program counter plus two.
// [RULE13] Decode dispatches to routine entry point.
// [RULE14] Service test after instruction, else fetch.
// [RULE15] User opcode range goes to user dispatch.
// [RULE16] Writable store holds 1024 words.
// [RULE17] Address and word registered at changeover.
// [RULE18] Reset starts at fetch routine address.
`timescale 1ns/1ps
`default_nettype none
`include "mss_defines.svh"
module mss_sequencer
  import mss_pkg::*;
#(
  parameter int UCYCLE_CLKS = `MSS_UCYCLE_CLKS,
  parameter int CS_WIDTH    = `MSS_UWORD_EXT_W,
  parameter int CS_DEPTH    = `MSS_CS_DEPTH
) (
  // Clock and reset.
  input  wire logic                    sys_clk_in,
  input  wire logic                    reset_n_in,
  // Control store.
  output logic [`MSS_UADDR_W-1:0]      cs_addr_out,
  input  wire logic [CS_WIDTH-1:0]     cs_word_in,
  // Main memory fetch.
  output logic                         mem_rd_out,
  output logic [15:0]                  mem_addr_out,
  input  wire logic [15:0]             mem_data_in,
  // Conditions.
  input  wire logic                    service_req_in,
  input  wire logic                    dp_carry_in,
  input  wire logic                    dp_zero_in,
  // Timing pulses.
  output logic                         phase_one_pulse_out,
  output logic                         phase_two_pulse_out,
  output logic                         phase_three_pulse_out,
  output logic                         micro_phase_three_pulse_out,
  // Datapath controls.
  output logic [3:0]                   alu_fn_out,
  output logic [7:0]                   literal_out,
  output logic                         literal_en_out,
  output logic [4:0]                   a_sel_out,
  output logic [4:0]                   b_sel_out,
  output logic [4:0]                   dst_sel_out,
  output logic                         d_load_out,
  output logic [1:0]                   sp_write_out,
  output logic [1:0]                   reg_clk_out,
  // Status.
  output logic [15:0]                  instruction_holding_register_out,
  output logic [15:0]                  pc_out,
  output logic [`MSS_UADDR_W-1:0]      uaddr_out
);
  initial begin
    // [RULE2] common bits only
    if (CS_WIDTH < `MSS_UWORD_W) begin
      $error("mss_sequencer: CS_WIDTH narrower than microword");
    end
    // [RULE16] store depth
    if (CS_DEPTH != (1 << `MSS_UADDR_W)) begin
      $error("mss_sequencer: CS_DEPTH must match address width");
    end
  end

  mss_timing_if tmg ();

  mss_phase_gen #(
    .UCYCLE_CLKS (UCYCLE_CLKS)
  ) u_phase (
    .sys_clk_in (sys_clk_in),
    .reset_n_in (reset_n_in),
    .tmg        (tmg)
  );

  mss_uword_t uword_r;
  mss_uaddr_t uaddr_r;
  mss_uaddr_t cs_addr_r;
  logic [15:0] ir_r;
  logic [15:0] pc_r;

  // [RULE1] one 48-bit microinstruction
  wire mss_uword_t  fetched_word = cs_word_in[`MSS_UWORD_W-1:0];

  // Field decode of the microword in control.
  wire logic [3:0]  f_alu    = uword_r[`MSS_F_ALU_HI:`MSS_F_ALU_LO];
  // [RULE7] literal overlays ALU field
  wire logic [7:0]  f_lit    = uword_r[`MSS_F_LIT_HI:`MSS_F_LIT_LO];
  wire logic        f_lit_en = uword_r[`MSS_F_LIT_EN];
  wire logic        f_fetch  = uword_r[`MSS_F_FETCH];
  wire logic        f_when   = uword_r[`MSS_F_WHEN];
  wire logic        f_clkd   = uword_r[`MSS_F_CLKD];
  wire logic        f_steer  = uword_r[`MSS_F_STEER];
  wire logic [1:0]  f_pair   = uword_r[`MSS_F_PAIR_HI:`MSS_F_PAIR_LO];
  wire mss_cond_e   f_cond   = mss_cond_e'(uword_r[`MSS_F_COND_HI:`MSS_F_COND_LO]);
  wire mss_seq_op_e f_seq    = mss_seq_op_e'(uword_r[`MSS_F_SEQ_HI:`MSS_F_SEQ_LO]);
  wire mss_uaddr_t  f_next   = uword_r[`MSS_F_NEXT_HI:`MSS_F_NEXT_LO];

  // [RULE4] branch condition evaluation
  logic cond_true;
  always_comb begin
    unique case (f_cond)
      MSS_COND_NONE:    cond_true = 1'b0;
      MSS_COND_CARRY:   cond_true = dp_carry_in;
      MSS_COND_ZERO:    cond_true = dp_zero_in;
      MSS_COND_SERVICE: cond_true = service_req_in;
      MSS_COND_NCARRY:  cond_true = !dp_carry_in;
      MSS_COND_NZERO:   cond_true = !dp_zero_in;
      MSS_COND_R6:      cond_true = 1'b0;
      MSS_COND_R7:      cond_true = 1'b0;
    endcase
  end

  // [RULE3] successor from next-address field
  wire mss_uaddr_t branch_addr = {f_next[`MSS_UADDR_W-1:1], f_next[0] | cond_true};

  // [RULE15] user opcode range
  wire logic user_extension_opcode =
    (ir_r[`MSS_USER_OPC_HI:`MSS_USER_OPC_LO] == `MSS_USER_OPC);
  // [RULE13] decode entry point
  wire mss_uaddr_t decode_addr = user_extension_opcode ? `MSS_USER_DISPATCH :
    {`MSS_DECODE_BASE, ir_r[`MSS_OPC_MAP_HI:`MSS_OPC_MAP_LO]};
  // [RULE14] service test or next fetch
  wire mss_uaddr_t service_addr = service_req_in ? `MSS_SERVICE_UADDR : f_next;

  logic [`MSS_UADDR_W-1:0] next_addr;
  always_comb begin
    unique case (f_seq)
      MSS_SEQ_NEXT:    next_addr = branch_addr;
      MSS_SEQ_DECODE:  next_addr = decode_addr;
      MSS_SEQ_SERVICE: next_addr = service_addr;
      MSS_SEQ_RSVD:    next_addr = branch_addr;
    endcase
  end

  // Successor is chosen at the start of P3 so the store has settled before changeover.
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      // [RULE18] fixed reset address
      cs_addr_r <= `MSS_RESET_UADDR;
    end else if (tmg.p3_begin) begin
      cs_addr_r <= next_addr;
    end
  end

  // [RULE17] capture at changeover
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      uword_r <= '0;
      uaddr_r <= `MSS_RESET_UADDR;
    end else if (tmg.changeover) begin
      // [RULE8] new word takes control
      uword_r <= fetched_word;
      uaddr_r <= cs_addr_r;
    end
  end

  // [RULE12] instruction fetch, advance by two
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      ir_r <= '0;
      pc_r <= `MSS_PC_RESET;
    end else if (f_fetch && tmg.p3_begin) begin
      ir_r <= mem_data_in;
      pc_r <= pc_r + `MSS_PC_STEP;
    end
  end

  // [RULE11] phase-timed transfers
  wire logic d_clk_phase = f_when ? tmg.p3 : tmg.p2;
  // [RULE6] steering of the bit pair
  wire logic [1:0] pair_sp  = f_steer ? 2'b00 : f_pair;
  wire logic [1:0] pair_reg = f_steer ? f_pair : 2'b00;

  // [RULE5] explicit operand and result fields
  assign a_sel_out   = uword_r[`MSS_F_ASRC_HI:`MSS_F_ASRC_LO];
  assign b_sel_out   = uword_r[`MSS_F_BSRC_HI:`MSS_F_BSRC_LO];
  assign dst_sel_out = uword_r[`MSS_F_DST_HI:`MSS_F_DST_LO];

  assign alu_fn_out     = f_alu;
  assign literal_out    = f_lit;
  assign literal_en_out = f_lit_en;
  assign d_load_out     = f_clkd & d_clk_phase;
  assign sp_write_out   = pair_sp & {2{tmg.p3}};
  assign reg_clk_out    = pair_reg & {2{tmg.p3}};

  // Memory address is the program counter, which steps just after P3 begin in a fetch word; data is taken at P3 begin.
  assign mem_rd_out   = f_fetch;
  assign mem_addr_out = pc_r;
  assign cs_addr_out  = cs_addr_r;

  assign phase_one_pulse_out         = tmg.p1;
  assign phase_two_pulse_out         = tmg.p2;
  assign phase_three_pulse_out       = tmg.p3;
  assign micro_phase_three_pulse_out = tmg.up3;

  assign instruction_holding_register_out = ir_r;
  assign pc_out                           = pc_r;
  assign uaddr_out                        = uaddr_r;
endmodule
`default_nettype wire
